/* File: logic/shared_timer_prescaler.v */
// Shared 10-bit prescaler with per-timer tick source selection,
// external count pin synchronizers and the general timer control register.
// Assumes one 40 MHz clock, synchronous active-high reset, pins synchronous
// to clk, and a register master that never issues read and write together.
// The timer counters sit outside; they see only one-cycle tick enables
// and the two prescaler reset levels.
`timescale 1ns/1ps
`include "shared_timer_prescaler_map.vh"

// Functional notes
// - Select 1 gives a tick every system clock cycle.
// - Prescaler offers taps at clock divided by 8, 64, 256, 1024.
// - One free-running prescaler serves both timers; each picks its own tap.
// - First prescaled tick comes 1 to N cycles after enabling.
// - Prescaler reset restarts the period for both timers.
// - Each count pin is sampled every cycle, synchronized, then edge-detected.
// - Synchronizer uses rising-edge flops only; the first stands for a clock-high latch stage.
// - Select 7 ticks on rising pin edges, select 6 on falling edges.
// - Pin edge to tick output takes about three system clock cycles.
// - External edges bypass the prescaler, never divided.
// - Sync-hold written one keeps the written prescaler reset bits asserted.
// - Sync-hold written zero clears both prescaler reset bits.
// - Sync reset bit resets prescaler; clears itself unless sync-hold is set.
module shared_timer_prescaler (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Register port
    input  wire [7:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata,
    // External count pins
    input  wire       external_count_pin_0,
    input  wire       external_count_pin_1,
    // Timer ticks, one-cycle enables
    output reg        timer_tick_0,
    output reg        timer_tick_1,
    // Prescaler reset levels seen by the timers
    output reg        sync_prescaler_reset,
    output reg        async_prescaler_reset
);

    // ==========================================================
    // Declarations
    // Shared prescaler
    reg  [`PRESCALER_WIDTH-1:0] count_q;
    reg  [`PRESCALER_WIDTH-1:0] count_d;
    wire                        count_run;
    wire                        psr_now;

    // General timer control state
    reg                         sync_hold_mode_q;
    reg                         sync_hold_mode_d;
    reg                         psr_sync_q;
    reg                         psr_sync_d;
    reg                         psr_async_q;
    reg                         psr_async_d;

    // Tick source selects
    reg  [2:0]                  sel0_q;
    reg  [2:0]                  sel1_q;

    // Register port decode and written fields
    wire                        wr_gtc;
    wire                        wr_tss;
    wire                        wr_hold_bit;
    wire                        wr_async_bit;
    wire                        wr_sync_bit;
    wire [2:0]                  wr_sel0;
    wire [2:0]                  wr_sel1;

    // Read path
    reg  [7:0]                  rdata_d;

    // Tap strobes and tick candidates
    reg                         tap8;
    reg                         tap64;
    reg                         tap256;
    reg                         tap1024;
    reg                         tick0_d;
    reg                         tick1_d;

    // Synchronized pin edges
    wire                        ext0_rise;
    wire                        ext0_fall;
    wire                        ext1_rise;
    wire                        ext1_fall;

    // ==========================================================
    // Register write decode
    assign wr_gtc = wr & (addr == `ADDR_GENERAL_TIMER_CONTROL);
    assign wr_tss = wr & (addr == `ADDR_TICK_SOURCE_SELECT);

    // Fields carried by a write, named once for the logic below
    assign wr_hold_bit  = wdata[`GTC_SYNC_HOLD_BIT];
    assign wr_async_bit = wdata[`GTC_ASYNC_RESET_BIT];
    assign wr_sync_bit  = wdata[`GTC_SYNC_RESET_BIT];
    assign wr_sel0      = wdata[`TSS_SEL0_LSB+2:`TSS_SEL0_LSB];
    assign wr_sel1      = wdata[`TSS_SEL1_LSB+2:`TSS_SEL1_LSB];

    // Prescaler is held in reset by the stored bit or a fresh write of one
    assign psr_now   = psr_sync_q | (wr_gtc & wr_sync_bit);
    // Taps may fire only while no prescaler reset is applied
    assign count_run = ~psr_now;

    // ==========================================================
    // General timer control: sync-hold and prescaler reset bits
    // A sync bit written without hold resets the counter for that one cycle
    // only, through psr_now; the stored copy lasts only while hold is set
    always @* begin
        sync_hold_mode_d = sync_hold_mode_q;
        psr_sync_d       = psr_sync_q;
        psr_async_d      = psr_async_q;
        if (wr_gtc) begin
            sync_hold_mode_d = wr_hold_bit;
            if (wr_hold_bit) begin
                // Hold mode keeps whatever was written
                psr_sync_d  = wr_sync_bit;
                psr_async_d = wr_async_bit;
            end else begin
                // Leaving or outside hold: both bits drop together
                psr_sync_d  = 1'b0;
                psr_async_d = 1'b0;
            end
        end
    end

    // Control register state
    always @(posedge clk) begin
        if (rst) begin
            sync_hold_mode_q <= 1'b0;
            psr_sync_q       <= 1'b0;
            psr_async_q      <= 1'b0;
        end else begin
            sync_hold_mode_q <= sync_hold_mode_d;
            psr_sync_q       <= psr_sync_d;
            psr_async_q      <= psr_async_d;
        end
    end

    // Reset levels driven out to the timers
    always @(posedge clk) begin
        if (rst) begin
            sync_prescaler_reset  <= 1'b0;
            async_prescaler_reset <= 1'b0;
        end else begin
            sync_prescaler_reset  <= psr_now;
            async_prescaler_reset <= psr_async_d;
        end
    end

    // ==========================================================
    // Tick source select register
    always @(posedge clk) begin
        if (rst) begin
            sel0_q <= `SEL_STOP;
            sel1_q <= `SEL_STOP;
        end else if (wr_tss) begin
            sel0_q <= wr_sel0;
            sel1_q <= wr_sel1;
        end
    end

    // ==========================================================
    // Shared free-running prescaler
    // Counts regardless of either select field; only its reset stops it
    // A select change does not restart it, so a newly chosen tap may fire
    // anywhere within its first period; a prescaler reset restarts every tap
    always @* begin
        if (psr_now) begin
            count_d = {`PRESCALER_WIDTH{1'b0}};
        end else begin
            count_d = count_q + {{(`PRESCALER_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // Prescaler counter
    always @(posedge clk) begin
        if (rst) begin
            count_q <= {`PRESCALER_WIDTH{1'b0}};
        end else begin
            count_q <= count_d;
        end
    end

    // Tap strobes: one cycle in every N, suppressed while held in reset
    always @* begin
        tap8    = count_run & ((count_q & `DIV8_MASK)    == `DIV8_MASK);
        tap64   = count_run & ((count_q & `DIV64_MASK)   == `DIV64_MASK);
        tap256  = count_run & ((count_q & `DIV256_MASK)  == `DIV256_MASK);
        tap1024 = count_run & ((count_q & `DIV1024_MASK) == `DIV1024_MASK);
    end

    // ==========================================================
    // External count pin synchronizers, one per timer
    // Pins are taken as synchronous to clk; edges never pass through the taps
    ext_pin_sync u_ext0 (
        .clk  (clk),
        .rst  (rst),
        .pin  (external_count_pin_0),
        .rise (ext0_rise),
        .fall (ext0_fall)
    );

    ext_pin_sync u_ext1 (
        .clk  (clk),
        .rst  (rst),
        .pin  (external_count_pin_1),
        .rise (ext1_rise),
        .fall (ext1_fall)
    );

    // ==========================================================
    // Tick source multiplexers
    // Each timer reads the shared taps through its own select field
    // Selects 6 and 7 take the synchronized edge pulses undivided
    always @* begin
        case (sel0_q)
            `SEL_STOP:     tick0_d = 1'b0;
            `SEL_DIRECT:   tick0_d = 1'b1;
            `SEL_DIV8:     tick0_d = tap8;
            `SEL_DIV64:    tick0_d = tap64;
            `SEL_DIV256:   tick0_d = tap256;
            `SEL_DIV1024:  tick0_d = tap1024;
            `SEL_EXT_FALL: tick0_d = ext0_fall;
            `SEL_EXT_RISE: tick0_d = ext0_rise;
            default:       tick0_d = 1'b0;
        endcase
    end

    // Second timer, same shared taps, independent choice
    always @* begin
        case (sel1_q)
            `SEL_STOP:     tick1_d = 1'b0;
            `SEL_DIRECT:   tick1_d = 1'b1;
            `SEL_DIV8:     tick1_d = tap8;
            `SEL_DIV64:    tick1_d = tap64;
            `SEL_DIV256:   tick1_d = tap256;
            `SEL_DIV1024:  tick1_d = tap1024;
            `SEL_EXT_FALL: tick1_d = ext1_fall;
            `SEL_EXT_RISE: tick1_d = ext1_rise;
            default:       tick1_d = 1'b0;
        endcase
    end

    // Registered tick outputs; pin edge reaches here on the third edge
    // Pin sampled at the first edge, synchronized at the second, ticked at
    // the third; the timer then counts on the fourth
    always @(posedge clk) begin
        if (rst) begin
            timer_tick_0 <= 1'b0;
            timer_tick_1 <= 1'b0;
        end else begin
            timer_tick_0 <= tick0_d;
            timer_tick_1 <= tick1_d;
        end
    end

    // ==========================================================
    // Register read path, data valid the cycle after the strobe
    // Count bytes are read one at a time; a carry between two reads is not caught
    always @* begin
        rdata_d = 8'h00;
        case (addr)
            `ADDR_GENERAL_TIMER_CONTROL: begin
                rdata_d[`GTC_SYNC_HOLD_BIT]   = sync_hold_mode_q;
                rdata_d[`GTC_ASYNC_RESET_BIT] = psr_async_q;
                rdata_d[`GTC_SYNC_RESET_BIT]  = psr_sync_q;
            end
            `ADDR_TICK_SOURCE_SELECT: begin
                rdata_d[`TSS_SEL0_LSB+2:`TSS_SEL0_LSB] = sel0_q;
                rdata_d[`TSS_SEL1_LSB+2:`TSS_SEL1_LSB] = sel1_q;
            end
            `ADDR_PRESCALER_COUNT_LO: begin
                rdata_d = count_q[7:0];
            end
            `ADDR_PRESCALER_COUNT_HI: begin
                rdata_d[1:0] = count_q[`PRESCALER_WIDTH-1:8];
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    // Read data register, zero outside read answers
    always @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            rdata <= rdata_d;
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule

/* File: logic/shared_timer_prescaler_map.vh */
// Register map, field positions, reset values and divider constants
// for the shared timer prescaler. Included by the prescaler design files.
`ifndef SHARED_TIMER_PRESCALER_MAP_VH
`define SHARED_TIMER_PRESCALER_MAP_VH

// ==========================================================
// Register offsets (8-bit register port)
`define ADDR_GENERAL_TIMER_CONTROL 8'h43
`define ADDR_TICK_SOURCE_SELECT    8'h44
`define ADDR_PRESCALER_COUNT_LO    8'h45
`define ADDR_PRESCALER_COUNT_HI    8'h46

// ==========================================================
// general_timer_control fields
`define GTC_SYNC_HOLD_BIT          7
`define GTC_ASYNC_RESET_BIT        1
`define GTC_SYNC_RESET_BIT         0
`define GTC_RESET_VALUE            8'h00

// ==========================================================
// tick_source_select fields: timer 0 in [2:0], timer 1 in [6:4]
`define TSS_SEL0_LSB               0
`define TSS_SEL1_LSB               4
`define TSS_RESET_VALUE            8'h00

// ==========================================================
// Tick source encodings
`define SEL_STOP                   3'h0
`define SEL_DIRECT                 3'h1
`define SEL_DIV8                   3'h2
`define SEL_DIV64                  3'h3
`define SEL_DIV256                 3'h4
`define SEL_DIV1024                3'h5
`define SEL_EXT_FALL               3'h6
`define SEL_EXT_RISE               3'h7

// ==========================================================
// Prescaler: 10-bit counter, tap reached when low bits are all ones
`define PRESCALER_WIDTH            10
`define DIV8_MASK                  10'h007
`define DIV64_MASK                 10'h03f
`define DIV256_MASK                10'h0ff
`define DIV1024_MASK               10'h3ff

`endif

/* File: logic/ext_pin_sync.v */
// Synchronizer and edge detector for one external count pin.
// Assumes the pin is sampled on the rising edge of clk, reset is synchronous.
`timescale 1ns/1ps

module ext_pin_sync (
    // Clock and reset
    input  wire clk,
    input  wire rst,
    // Pin
    input  wire pin,
    // Edge pulses, one cycle each
    output wire rise,
    output wire fall
);

    reg meta_q;
    reg sync_q;
    reg prev_q;

    // ==========================================================
    // Sampling chain
    // First stage stands for the clock-high latch; only sync_q reads it
    always @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edge compare on synchronized samples only
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

endmodule

/* File: verif/stp_props.sv */
// Concurrent checks on the ports of the shared timer prescaler.
// Assumes binding to shared_timer_prescaler and the register map header.
`timescale 1ns/1ps
`include "shared_timer_prescaler_map.vh"
// ==========================================
// Port checker
module stp_props (
    // Clock and reset
    input wire       clk,
    input wire       rst,
    // Register port
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata,
    // Pins, ticks and reset levels
    input wire       external_count_pin_0,
    input wire       external_count_pin_1,
    input wire       timer_tick_0,
    input wire       timer_tick_1,
    input wire       sync_prescaler_reset,
    input wire       async_prescaler_reset
);
    reg  [2:0] sel0_q;
    reg  [2:0] sel1_q;
    wire       gtc_wr = wr && addr == `ADDR_GENERAL_TIMER_CONTROL;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Shadow of the tick source selects, updated on the same edge as the design
    always @(posedge clk) begin
        if (rst) begin
            sel0_q <= 3'h0;
            sel1_q <= 3'h0;
        end else if (wr && addr == `ADDR_TICK_SOURCE_SELECT) begin
            sel0_q <= wdata[2:0];
            sel1_q <= wdata[6:4];
        end
    end
    // Tick relations
    property p_stop0; $past(sel0_q) == `SEL_STOP |-> !timer_tick_0; endproperty
    a_stop0: assert property (p_stop0) else $error("tick 0 while stopped");
    property p_direct1; $past(sel1_q) == `SEL_DIRECT |-> timer_tick_1; endproperty
    a_direct1: assert property (p_direct1) else $error("direct tick 1 missing");
    property p_div8;
        (timer_tick_0 && !wr && sel0_q == `SEL_DIV8 && $past(sel0_q) == `SEL_DIV8)
            ##1 !wr [*7] |=> timer_tick_0;
    endproperty
    a_div8: assert property (p_div8) else $error("div8 period wrong");
    property p_tap_halt;
        sync_prescaler_reset && $past(sync_prescaler_reset) &&
            $past(sel1_q) inside {[3'h2:3'h5]} |-> !timer_tick_1;
    endproperty
    a_tap_halt: assert property (p_tap_halt) else $error("tap tick in reset");
    property p_ext_rise0;
        $rose(external_count_pin_0) && sel0_q == `SEL_EXT_RISE
            |-> ##[3:4] timer_tick_0 ##1 !timer_tick_0;
    endproperty
    a_ext_rise0: assert property (p_ext_rise0) else $error("rise tick late");
    property p_ext_fall1;
        $fell(external_count_pin_1) && sel1_q == `SEL_EXT_FALL
            |-> ##[3:4] timer_tick_1 ##1 !timer_tick_1;
    endproperty
    a_ext_fall1: assert property (p_ext_fall1) else $error("fall tick late");
    // Control register relations
    property p_hold; (gtc_wr && wdata[7] && wdata[0]) ##1 !wr |=> sync_prescaler_reset; endproperty
    a_hold: assert property (p_hold) else $error("held reset dropped");
    property p_release;
        (gtc_wr && !wdata[7]) ##1 !wr [*3] |-> !sync_prescaler_reset && !async_prescaler_reset;
    endproperty
    a_release: assert property (p_release) else $error("reset bits not cleared");
    // Main scenarios reached
    c_div8: cover property (timer_tick_0 && sel0_q == `SEL_DIV8);
    c_hold: cover property (sync_prescaler_reset [*2]);
    c_rise: cover property ($rose(external_count_pin_0) && sel0_q == `SEL_EXT_RISE);
endmodule

/* File: verif/timer_pair_model.sv */
// Model of the two timer counters that consume the ticks.
// Assumes ticks are one-cycle enables on clk.
`timescale 1ns/1ps
// ==========================================
// Tick counting timers
module timer_pair_model (
    // Clock, reset and count clear
    input  wire        clk,
    input  wire        rst,
    input  wire        clr,
    // Ticks in, counts out
    input  wire        tick_0,
    input  wire        tick_1,
    output reg  [15:0] count_0,
    output reg  [15:0] count_1
);
    // Each timer advances by one on every tick it is given while rst and clr are low
    always @(posedge clk) begin
        if (rst || clr) begin
            count_0 <= 16'h0000;
            count_1 <= 16'h0000;
        end else begin
            count_0 <= count_0 + {15'h0000, tick_0};
            count_1 <= count_1 + {15'h0000, tick_1};
        end
    end
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the shared timer prescaler.
// Assumes the design, the timer model and the checker are compiled before it.
`timescale 1ns/1ps
`include "shared_timer_prescaler_map.vh"
// ==========================================
// Bench top
module tb_top;
    logic        clk;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        pin_0 = 1'b0;
    logic        pin_1 = 1'b0;
    logic        clr = 1'b0;
    wire  [7:0]  rdata;
    wire         tick_0;
    wire         tick_1;
    wire         sync_rst;
    wire         async_rst;
    wire  [15:0] count_0;
    wire  [15:0] count_1;
    int          err_count = 0;
    int          n_checks = 0;
    logic [7:0]  sel_t [3] = '{8'h12, 8'h43, 8'h05};
    int          win_t [3] = '{64, 512, 2048};
    logic [15:0] e0_t [3] = '{16'd8, 16'd8, 16'd2};
    logic [15:0] e1_t [3] = '{16'd64, 16'd2, 16'd0};
    shared_timer_prescaler shared_timer_prescaler_inst (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .external_count_pin_0(pin_0),
        .external_count_pin_1(pin_1), .timer_tick_0(tick_0), .timer_tick_1(tick_1),
        .sync_prescaler_reset(sync_rst), .async_prescaler_reset(async_rst));
    timer_pair_model timer_pair_model_inst (.clk(clk), .rst(rst), .clr(clr), .tick_0(tick_0),
        .tick_1(tick_1), .count_0(count_0), .count_1(count_1));
    // 25 ns clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Compare and count
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One-cycle register accesses
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        check("rdata", {8'h00, rdata}, {8'h00, exp});
    endtask
    // Clear the timer counts, then let a number of edges pass
    task automatic window(input int n);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (n + 1) @(posedge clk);
    endtask
    // Restart the prescaler by a control write and time the first div8 and div64 ticks
    task automatic release_chk(input logic [7:0] d);
        @(posedge clk);
        clr <= 1'b1;
        wr_reg(`ADDR_GENERAL_TIMER_CONTROL, d);
        clr <= 1'b0;
        repeat (9) @(posedge clk);
        check("first div8", count_0, 16'h0000);
        @(posedge clk);
        check("first div8", count_0, 16'h0001);
        repeat (55) @(posedge clk);
        check("first div64", count_1, 16'h0000);
        @(posedge clk);
        check("first div64", count_1, 16'h0001);
    endtask
    // Verdict
    task automatic test_done;
        if (err_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_reg(`ADDR_GENERAL_TIMER_CONTROL, `GTC_RESET_VALUE);
        rd_reg(`ADDR_TICK_SOURCE_SELECT, `TSS_RESET_VALUE);
        for (int i = 0; i < 3; i++) begin
            wr_reg(`ADDR_TICK_SOURCE_SELECT, sel_t[i]);
            rd_reg(`ADDR_TICK_SOURCE_SELECT, sel_t[i]);
            window(win_t[i]);
            check("ticks 0", count_0, e0_t[i]);
            check("ticks 1", count_1, e1_t[i]);
        end
        wr_reg(`ADDR_TICK_SOURCE_SELECT, 8'h32);
        release_chk(8'h01);
        rd_reg(`ADDR_GENERAL_TIMER_CONTROL, 8'h00);
        wr_reg(`ADDR_GENERAL_TIMER_CONTROL, 8'h83);
        rd_reg(`ADDR_GENERAL_TIMER_CONTROL, 8'h83);
        window(100);
        check("held ticks 0", count_0, 16'h0000);
        check("sync level", {15'h0000, sync_rst}, 16'h0001);
        check("async level", {15'h0000, async_rst}, 16'h0001);
        release_chk(8'h00);
        rd_reg(`ADDR_GENERAL_TIMER_CONTROL, 8'h00);
        // Counter restarted by that write and ran freely: 68, then 70 cycles on
        rd_reg(`ADDR_PRESCALER_COUNT_LO, 8'h44);
        rd_reg(`ADDR_PRESCALER_COUNT_HI, 8'h00);
        // Pins held low while the source changes, phases of five cycles
        for (int k = 0; k < 2; k++) begin
            wr_reg(`ADDR_TICK_SOURCE_SELECT, (k == 0) ? 8'h67 : 8'h76);
            window(4);
            repeat (5) begin
                pin_0 <= 1'b1;
                pin_1 <= 1'b1;
                repeat (5) @(posedge clk);
                pin_0 <= 1'b0;
                pin_1 <= 1'b0;
                repeat (5) @(posedge clk);
            end
            repeat (6) @(posedge clk);
            check("ext ticks 0", count_0, 16'd5);
            check("ext ticks 1", count_1, 16'd5);
        end
        test_done();
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        test_done();
    end
endmodule
bind shared_timer_prescaler stp_props stp_props_inst (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .external_count_pin_0(external_count_pin_0),
    .external_count_pin_1(external_count_pin_1), .timer_tick_0(timer_tick_0),
    .timer_tick_1(timer_tick_1), .sync_prescaler_reset(sync_prescaler_reset),
    .async_prescaler_reset(async_prescaler_reset));
